//--- hdl/pps_map.vh
`ifndef PPS_MAP_VH
`define PPS_MAP_VH
// Register byte offsets
`define PPS_OFF_DIR     12'h000
`define PPS_OFF_OUT     12'h004
`define PPS_OFF_IN      12'h008
`define PPS_OFF_ALT     12'h00c
`define PPS_OFF_NET     12'h010
`define PPS_OFF_SER     12'h014
`define PPS_OFF_FSD     12'h018
`define PPS_OFF_STAT    12'h01c
// Reset values
`define PPS_RST_DIR     8'h00
`define PPS_RST_OUT     8'h00
`define PPS_RST_ALT     8'h00
`define PPS_RST_NET     3'h0
`define PPS_RST_SER     2'h0
// Field positions
`define PPS_SER_AUX     0
`define PPS_SER_SPI     1
`define PPS_STAT_FSD    0
`define PPS_STAT_CONF   1
`define PPS_LED_BIT     7
// Network states
`define PPS_NET_OFF     3'h0
`define PPS_NET_UNREG   3'h1
`define PPS_NET_IDLE    3'h2
`define PPS_NET_PSM     3'h3
`define PPS_NET_CONN    3'h4
// Timing
`define PPS_CLK_HZ      10000000
`define PPS_ON_MS       1000
`define PPS_OFF_MS      2000
`endif

//--- hdl/pps_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser per bit; change accepted when stages 2 and 3 agree
module pps_sync #(
   parameter W = 8
) (
   input  wire         CLK,
   input  wire         RST_B,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] s1_reg;   // First stage, read only by second
   reg [W-1:0] s2_reg;   // Second stage
   reg [W-1:0] s3_reg;   // Third stage
   reg [W-1:0] q_reg;    // Accepted level

   assign dout = q_reg;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         // Shift chain and agreement filter
         always @(posedge CLK) begin
            if (!RST_B) begin
               s1_reg[i] <= 1'b0;
               s2_reg[i] <= 1'b0;
               s3_reg[i] <= 1'b0;
               q_reg[i]  <= 1'b0;
            end else begin
               s1_reg[i] <= din[i];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i]) begin
                  q_reg[i] <= s3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule // pps_sync

//--- hdl/pps_top.v
// Notes on behaviour
// - Input read returns current pad level
// - Output value writable and read back
// - Alternate pads driven by internal function
// - All pads default to input, pulldown
// - Outputs drive push-pull both levels
// - Status indicator only on pin eight alternate
// - Indicator off when off, on unregistered
// - Idle/connecting: one second on, two off
// - Power saving: toggles on wake events only
// - Aux serial and sync port exclusive
// - Aux serial: transmit out, receive in
// - Fast-shutdown pin falling edge starts power-down
`timescale 1ns/1ps
`include "pps_map.vh"
module pps_top #(
   parameter integer ON_CYC  = `PPS_CLK_HZ / 1000 * `PPS_ON_MS,
   parameter integer OFF_CYC = `PPS_CLK_HZ / 1000 * `PPS_OFF_MS
) (
   input  wire        CLK,
   input  wire        RST_B,
   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // Pads
   input  wire [7:0]  PAD_IN,
   output reg  [7:0]  PAD_OUT,
   output reg  [7:0]  PAD_OE,
   output reg  [7:0]  PAD_PD,
   // Firmware-side status and serial
   input  wire        WAKE_EVT,
   input  wire        AUX_TX,
   output reg         AUX_RX,
   input  wire        SPI_MOSI_DO,
   input  wire        SPI_MOSI_OE,
   output reg         SPI_MISO_DI,
   output reg         FAST_SHDN
);
   // Pad map for shared serial lines
   localparam [2:0] TXP = 3'd0;      // Aux transmit / sync data out pad
   localparam [2:0] RXP = 3'd1;      // Aux receive / sync data in pad
   localparam [1:0] CW  = 2'd2;      // Counter width helper
   localparam [2:0] ST_IDLE = 3'b001; // Not blinking: off, unregistered, power saving
   localparam [2:0] ST_ON   = 3'b010; // Blink on-phase
   localparam [2:0] ST_OFF  = 3'b100; // Blink off-phase

   reg  [7:0]  dir_reg;        // 1 = output
   reg  [7:0]  out_reg;        // Output values
   reg  [7:0]  alt_reg;        // 1 = alternate function
   reg  [2:0]  net_reg;        // Network state from firmware
   reg  [1:0]  ser_reg;        // Serial function select
   reg  [7:0]  fsd_reg;        // Fast-shutdown pin enables
   reg         fsd_st_reg;     // Sticky fast-shutdown event
   reg         conf_reg;       // Sticky serial conflict refused
   reg  [2:0]  st_reg;         // Blink state, one-hot
   reg  [2:0]  st_next;
   reg  [31:0] cnt_reg;        // Blink phase counter
   reg  [31:0] cnt_next;
   reg         led_reg;        // Indicator level
   reg         led_next;
   reg         wake_prev_reg;  // Wake event edge detect
   reg  [7:0]  prev_reg;       // Previous synchronised pads
   wire [7:0]  pin_s;          // Synchronised pad levels
   wire        wr_acc;         // Write in access phase
   wire        rd_acc;         // Read in access phase
   wire [1:0]  ser_req;        // Requested serial select
   wire [7:0]  fall;           // Falling edges per pad
   reg  [31:0] rd_mux;         // Read data select
   reg         rd_err;         // Unmapped address

   // Pad synchronisers
   pps_sync #(.W(8)) u_sync (
      .CLK   (CLK),
      .RST_B (RST_B),
      .din   (PAD_IN),
      .dout  (pin_s)
   );

   assign wr_acc  = PSEL & PENABLE & PWRITE;
   assign rd_acc  = PSEL & PENABLE & ~PWRITE;
   assign ser_req = PWDATA[1:0];
   assign fall    = prev_reg & ~pin_s;

   // Register writes; both serial functions at once is refused
   always @(posedge CLK) begin
      if (!RST_B) begin
         dir_reg  <= `PPS_RST_DIR;
         out_reg  <= `PPS_RST_OUT;
         alt_reg  <= `PPS_RST_ALT;
         net_reg  <= `PPS_RST_NET;
         ser_reg  <= `PPS_RST_SER;
         fsd_reg  <= 8'h00;
         conf_reg <= 1'b0;
      end else if (wr_acc) begin
         case (PADDR)
            `PPS_OFF_DIR: dir_reg <= PWDATA[7:0];
            `PPS_OFF_OUT: out_reg <= PWDATA[7:0];
            `PPS_OFF_ALT: alt_reg <= PWDATA[7:0];
            `PPS_OFF_NET: net_reg <= PWDATA[2:0];
            `PPS_OFF_FSD: fsd_reg <= PWDATA[7:0];
            `PPS_OFF_SER: begin
               if (ser_req == 2'b11) begin
                  conf_reg <= 1'b1;
               end else begin
                  ser_reg <= ser_req;
               end
            end
            `PPS_OFF_STAT: begin
               if (PWDATA[`PPS_STAT_CONF]) begin
                  conf_reg <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // Fast-shutdown detect; new event wins over a clear
   always @(posedge CLK) begin
      if (!RST_B) begin
         prev_reg   <= 8'h00;
         fsd_st_reg <= 1'b0;
         FAST_SHDN  <= 1'b0;
      end else begin
         prev_reg  <= pin_s;
         FAST_SHDN <= |(fall & fsd_reg & ~dir_reg);
         if (|(fall & fsd_reg & ~dir_reg)) begin
            fsd_st_reg <= 1'b1;
         end else if (wr_acc && PADDR == `PPS_OFF_STAT && PWDATA[`PPS_STAT_FSD]) begin
            fsd_st_reg <= 1'b0;
         end
      end
   end

   // Read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (PADDR)
         `PPS_OFF_DIR:  rd_mux = {24'h000000, dir_reg};
         `PPS_OFF_OUT:  rd_mux = {24'h000000, out_reg};
         `PPS_OFF_IN:   rd_mux = {24'h000000, pin_s};
         `PPS_OFF_ALT:  rd_mux = {24'h000000, alt_reg};
         `PPS_OFF_NET:  rd_mux = {29'h00000000, net_reg};
         `PPS_OFF_SER:  rd_mux = {30'h00000000, ser_reg};
         `PPS_OFF_FSD:  rd_mux = {24'h000000, fsd_reg};
         `PPS_OFF_STAT: rd_mux = {29'h00000000, led_reg, conf_reg, fsd_st_reg};
         default:       rd_err = 1'b1;
      endcase
   end

   // APB answer: no wait state, ready in the access cycle after setup
   always @(posedge CLK) begin
      if (!RST_B) begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & rd_err;
         if (PSEL & ~PENABLE & ~PWRITE) begin
            PRDATA <= rd_mux;
         end
      end
   end

   // Blink state machine
   always @* begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      led_next = led_reg;
      case (net_reg)
         `PPS_NET_OFF: begin
            st_next  = ST_IDLE;
            cnt_next = 32'h0000_0000;
            led_next = 1'b0;
         end
         `PPS_NET_UNREG: begin
            st_next  = ST_IDLE;
            cnt_next = 32'h0000_0000;
            led_next = 1'b1;
         end
         `PPS_NET_PSM: begin
            // Follows paging wakeups, no timer
            st_next  = ST_IDLE;
            cnt_next = 32'h0000_0000;
            if (WAKE_EVT & ~wake_prev_reg) begin
               led_next = ~led_reg;
            end
         end
         `PPS_NET_IDLE, `PPS_NET_CONN: begin
            case (st_reg)
               ST_ON: begin
                  led_next = 1'b1;
                  if (cnt_reg >= ON_CYC - 1) begin
                     st_next  = ST_OFF;
                     cnt_next = 32'h0000_0000;
                     led_next = 1'b0;
                  end else begin
                     cnt_next = cnt_reg + 32'h0000_0001;
                  end
               end
               ST_OFF: begin
                  led_next = 1'b0;
                  if (cnt_reg >= OFF_CYC - 1) begin
                     st_next  = ST_ON;
                     cnt_next = 32'h0000_0000;
                     led_next = 1'b1;
                  end else begin
                     cnt_next = cnt_reg + 32'h0000_0001;
                  end
               end
               default: begin
                  // Entry into blinking starts with on-phase
                  st_next  = ST_ON;
                  cnt_next = 32'h0000_0000;
                  led_next = 1'b1;
               end
            endcase
         end
         default: begin
            st_next  = ST_IDLE;
            cnt_next = 32'h0000_0000;
            led_next = 1'b0;
         end
      endcase
   end

   // Blink registers
   always @(posedge CLK) begin
      if (!RST_B) begin
         st_reg        <= ST_IDLE;
         cnt_reg       <= 32'h0000_0000;
         led_reg       <= 1'b0;
         wake_prev_reg <= 1'b0;
      end else begin
         st_reg        <= st_next;
         cnt_reg       <= cnt_next;
         led_reg       <= led_next;
         wake_prev_reg <= WAKE_EVT;
      end
   end

   // Pad drivers; alternate functions override the value register
   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1) begin : g_pad
         always @(posedge CLK) begin
            if (!RST_B) begin
               PAD_OUT[p] <= 1'b0;
               PAD_OE[p]  <= 1'b0;
               PAD_PD[p]  <= 1'b1;
            end else if (p == `PPS_LED_BIT && alt_reg[p]) begin
               PAD_OUT[p] <= led_reg;
               PAD_OE[p]  <= 1'b1;
               PAD_PD[p]  <= 1'b0;
            end else if (p == TXP && ser_reg[`PPS_SER_AUX]) begin
               PAD_OUT[p] <= AUX_TX;
               PAD_OE[p]  <= 1'b1;
               PAD_PD[p]  <= 1'b0;
            end else if (p == TXP && ser_reg[`PPS_SER_SPI]) begin
               PAD_OUT[p] <= SPI_MOSI_DO;
               PAD_OE[p]  <= SPI_MOSI_OE;
               PAD_PD[p]  <= 1'b0;
            end else if (p == RXP && ser_reg != 2'b00) begin
               PAD_OUT[p] <= 1'b0;
               PAD_OE[p]  <= 1'b0;
               PAD_PD[p]  <= 1'b0;
            end else begin
               PAD_OUT[p] <= out_reg[p];
               PAD_OE[p]  <= dir_reg[p];
               PAD_PD[p]  <= ~dir_reg[p];
            end
         end
      end
   endgenerate

   // Receive line to the active serial function only
   always @(posedge CLK) begin
      if (!RST_B) begin
         AUX_RX      <= 1'b1;
         SPI_MISO_DI <= 1'b0;
      end else begin
         AUX_RX      <= ser_reg[`PPS_SER_AUX] ? pin_s[RXP] : 1'b1;
         SPI_MISO_DI <= ser_reg[`PPS_SER_SPI] ? pin_s[RXP] : 1'b0;
      end
   end

   // Counter width helper kept for clarity of phase math
   wire unused_cw = ^CW;
endmodule // pps_top

//--- tb/pps_board.sv
`timescale 1ns/1ps
module pps_board (
   input  wire [7:0] pad_out,
   input  wire [7:0] pad_oe,
   input  wire [7:0] pad_pd,
   input  wire [7:0] ext_val,
   input  wire [7:0] ext_en,
   output wire [7:0] pad_lvl
);
   // Module drive wins; else board driver; else pull-down low, floating high
   assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & ~pad_pd);
endmodule // pps_board

//--- tb/pps_top_chk.sv
`timescale 1ns/1ps
module pps_top_chk (
   input wire        CLK,
   input wire        RST_B,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire [7:0]  PAD_IN,
   input wire [7:0]  PAD_OE,
   input wire [7:0]  PAD_PD,
   input wire        FAST_SHDN
);
   // One clock domain, reset quiets all checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Bus answers exactly one cycle after setup
   ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("ready missing after setup");
   ready_has_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
      else $error("ready without setup");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error flag outside access");
   err_reads_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("refused read not zero");
   // Pull-down only where the pad is not driven
   pull_on_input_a: assert property ((PAD_OE & PAD_PD) == 8'h00)
      else $error("pull-down on driven pad");
   reset_pads_a: assert property ($rose(RST_B) |-> PAD_OE == 8'h00 && PAD_PD == 8'hff)
      else $error("pads not inputs after reset");
   shdn_one_cycle_a: assert property (FAST_SHDN |=> !FAST_SHDN)
      else $error("shutdown pulse too long");
   // Synchroniser stages forbid an instant reaction
   shdn_synced_a: assert property ($fell(PAD_IN[0]) |=> !FAST_SHDN [*2])
      else $error("shutdown faster than synchroniser");
   cover property (FAST_SHDN);
   cover property (PSLVERR);
   cover property (PREADY && PWRITE);
endmodule // pps_top_chk

bind pps_top pps_top_chk pps_top_chk_i (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PAD_IN(PAD_IN), .PAD_OE(PAD_OE), .PAD_PD(PAD_PD),
   .FAST_SHDN(FAST_SHDN));

//--- tb/pps_top_tb.sv
`timescale 1ns/1ps
`include "pps_map.vh"
module pps_top_tb;
   reg         CLK, RST_B, PSEL, PENABLE, PWRITE, WAKE_EVT, AUX_TX, er;
   reg  [11:0] PADDR;
   reg  [31:0] PWDATA, rnd, rd;
   reg  [31:0] mdl [0:7];   // Register model, one word each
   reg  [7:0]  ext_val, ext_en;
   wire [31:0] PRDATA;
   wire        PREADY, PSLVERR, AUX_RX, SPI_MISO_DI, FAST_SHDN;
   wire [7:0]  PAD_IN, PAD_OUT, PAD_OE, PAD_PD;
   integer     error_cnt = 0, tests_run = 0, cyc = 0, i, n;
   integer     tog, onc;    // Indicator toggles and on-cycles in a window
   // Short blink counts keep the run brief
   pps_top #(.ON_CYC(10), .OFF_CYC(20)) pps_top_i (.CLK(CLK), .RST_B(RST_B),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_PD(PAD_PD),
      .WAKE_EVT(WAKE_EVT), .AUX_TX(AUX_TX), .AUX_RX(AUX_RX), .SPI_MOSI_DO(1'b0),
      .SPI_MOSI_OE(1'b0), .SPI_MISO_DI(SPI_MISO_DI), .FAST_SHDN(FAST_SHDN));
   pps_board pps_board_i (.pad_out(PAD_OUT), .pad_oe(PAD_OE), .pad_pd(PAD_PD),
      .ext_val(ext_val), .ext_en(ext_en), .pad_lvl(PAD_IN));
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task chk(input string what, input [31:0] exp, input [31:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("Error %s exp %h got %h", what, exp, got);
      end
   endtask
   // One transfer; request held until ready seen, then released
   task apb(input w, input [11:0] a, input [31:0] d);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      // Ready, read data and error are taken at the rising edge itself
      @(posedge CLK);
      while (PREADY !== 1'b1 && n < 20) begin
         @(posedge CLK);
         n = n + 1;
      end
      if (n == 20) begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // Model: read-only words and a clashing serial mode are ignored
      if (w && a < 12'h020 && a != `PPS_OFF_IN && a != `PPS_OFF_STAT
          && !(a == `PPS_OFF_SER && d[1:0] == 2'h3))
         mdl[a[4:2]] = d & ((a == `PPS_OFF_NET) ? 32'h7
                            : (a == `PPS_OFF_SER) ? 32'h3 : 32'hff);
      // One idle edge so the next call never reassigns the strobes at once
      @(posedge CLK);
   endtask
   task rdc(input [11:0] a);
      apb(1'b0, a, 32'h0);
      chk("read", mdl[a[4:2]], rd);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge CLK) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
   end
   initial begin
      {RST_B, PSEL, PENABLE, PWRITE, WAKE_EVT, PADDR, PWDATA} = 0;
      {ext_val, ext_en} = 16'h0;
      AUX_TX = 1'b1;
      rnd = 32'h5cfb;
      for (i = 0; i < 8; i = i + 1) mdl[i] = 32'h0;
      repeat (2) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      chk("pd", 8'hff, PAD_PD);
      for (i = 0; i < 8; i = i + 1) rdc(12'(i * 4));
      $display("reset test done");
      wr_t(`PPS_OFF_DIR, 32'hff);
      repeat (3) begin
         rnd = lfsr(rnd);
         wr_t(`PPS_OFF_OUT, rnd);
         rdc(`PPS_OFF_OUT);
         @(negedge CLK);
         chk("pads", {8'hff, rnd[7:0], 8'h00}, {PAD_OE, PAD_OUT, PAD_PD});
         @(posedge CLK);
      end
      $display("output test done");
      wr_t(`PPS_OFF_DIR, 32'h0);
      wr_t(`PPS_OFF_IN, 32'h5a);
      ext_en <= 8'hff;
      repeat (3) begin
         rnd = lfsr(rnd);
         ext_val <= rnd[7:0];
         mdl[2] = rnd[7:0];
         repeat (6) @(posedge CLK);
         rdc(`PPS_OFF_IN);
      end
      $display("input test done");
      ext_val <= 8'hff;
      wr_t(`PPS_OFF_FSD, 32'h1);
      repeat (6) @(posedge CLK);
      ext_val <= 8'hfe;
      n = 0;
      while (FAST_SHDN !== 1'b1 && n < 12) begin
         @(negedge CLK);
         n = n + 1;
      end
      chk("shdn", 1, FAST_SHDN);
      @(posedge CLK);
      mdl[7] = 1;
      rdc(`PPS_OFF_STAT);
      wr_t(`PPS_OFF_STAT, 32'h1);
      wr_t(`PPS_OFF_FSD, 32'h0);
      wr_t(`PPS_OFF_SER, 32'h3);
      mdl[7] = 2;
      rdc(`PPS_OFF_STAT);
      rdc(`PPS_OFF_SER);
      wr_t(`PPS_OFF_STAT, 32'h2);
      mdl[7] = 0;
      wr_t(`PPS_OFF_SER, 32'h1);
      AUX_TX <= 1'b0;
      ext_en <= 8'hfe;
      ext_val <= 8'h00;
      repeat (6) @(negedge CLK);
      chk("aux", 3'b100, {PAD_OE[0], PAD_OUT[0], AUX_RX});
      @(posedge CLK);
      wr_t(`PPS_OFF_SER, 32'h0);
      $display("shutdown and serial tests done");
      wr_t(`PPS_OFF_ALT, 32'h80);
      for (i = 0; i < 5; i = i + 1) begin
         wr_t(`PPS_OFF_NET, i);
         repeat (5) @(negedge CLK);
         tog = 0;
         onc = 0;
         rd[0] = PAD_OUT[7];
         // One full blink period: any 30-cycle window holds 10 on-cycles
         for (n = 0; n < 30; n = n + 1) begin
            @(posedge CLK);
            WAKE_EVT <= (i == 3 && n == 8);
            #1 er = PAD_OUT[7];
            tog = tog + (er !== rd[0]);
            onc = onc + er;
            rd[0] = er;
         end
         if (i < 2) chk("led", i, er);
         if (i == 2 || i == 4) chk("on_cnt", 10, onc);
         if (i == 2 || i == 4) chk("blink_edges", 2, tog);
         if (i == 3) chk("psm_toggles", 1, tog);
      end
      wr_t(`PPS_OFF_NET, 32'h1);
      wr_t(`PPS_OFF_DIR, 32'h80);
      wr_t(`PPS_OFF_ALT, 32'h0);
      repeat (3) @(negedge CLK);
      chk("gpio8", mdl[1][7], PAD_OUT[7]);
      @(posedge CLK);
      apb(1'b1, 12'h024, 32'hff);
      chk("slverr", 1, er);
      apb(1'b0, 12'h020, 32'h0);
      chk("err_rd", {1'b1, 32'h0}, {er, rd});
      rdc(`PPS_OFF_DIR);
      $display("indicator and bus tests done");
      wrap_up;
   end
   task wr_t(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
endmodule // pps_top_tb
